// ### hdl/fpc_pipe_ctrl.sv
// Pipeline-mode control of the accelerator: holding registers, pipeline, fault halt, APB registers
`timescale 1ns/1ps
`default_nettype none
module fpc_pipe_ctrl (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Host transaction side signals
  input wire logic i_op_start_qualifier,
  output logic o_coproc_available
);
  localparam fpc_pkg::fpc_stage_t STAGE_NONE = '0;

  logic [31:0] mode_q;
  logic [fpc_pkg::EXC_W-1:0] exc_q;
  logic es_q;
  logic [fpc_pkg::EXC_W-1:0] mask_q;
  logic [31:0] prec_q;
  logic [31:0] r_tmp_q, s_tmp_q, i_tmp_q;
  logic r_w_q, s_w_q, i_w_q, pending_q;
  logic [31:0] r_q, s_q, i_q;
  logic [63:0] f_q;
  logic [fpc_pkg::FLG_W-1:0] flg_q;
  logic [31:0] rf_q [fpc_pkg::RF_DEPTH];
  fpc_pkg::fpc_stage_t s1_q, s2_q, s3_q, nst, out;
  logic [3:0] cyc_q, len, len_raw;
  logic halted_q;

  logic pl, hen, access, stall, done, err, wr_ok, start, timer_ok;
  logic is_out_rd, is_opw, is_save, mapped, unmasked, out_fault, inval;
  logic [31:0] new_r, new_s, new_i, opnd_s, rdata;
  logic [1:0] opc;

  assign pl = mode_q[fpc_pkg::MODE_PL_BIT];
  assign hen = mode_q[fpc_pkg::MODE_HALT_BIT];
  assign access = i_psel && i_penable;
  assign unmasked = |(exc_q & ~mask_q);

  always_comb begin
    is_out_rd = (i_paddr == fpc_pkg::A_RES_HI) || (i_paddr == fpc_pkg::A_RES_LO) ||
                (i_paddr == fpc_pkg::A_FLAGS) || (i_paddr == fpc_pkg::A_STATUS);
    is_opw = (i_paddr == fpc_pkg::A_OPR_R) || (i_paddr == fpc_pkg::A_OPR_S) ||
             (i_paddr == fpc_pkg::A_INSTR);
    is_save = (i_paddr == fpc_pkg::A_SAVE_R) || (i_paddr == fpc_pkg::A_SAVE_S) ||
              (i_paddr == fpc_pkg::A_SAVE_I);
    mapped = is_out_rd || is_opw || is_save || (i_paddr == fpc_pkg::A_MODE) ||
             (i_paddr == fpc_pkg::A_MASK) || (i_paddr == fpc_pkg::A_PREC);
  end

  // A halted device never starts, so stalling there would lock the host out
  assign stall = access && pending_q && !halted_q &&
                 ((!i_pwrite && is_out_rd) || (i_pwrite && is_opw));
  assign o_pready = !stall;
  assign done = access && !stall;

  always_comb begin
    err = 1'b0;
    if (!mapped) begin
      err = 1'b1;
    end else if (is_save && pl) begin
      err = 1'b1;
    end else if (is_save && i_pwrite) begin
      err = 1'b1;
    end else if (!i_pwrite && is_out_rd && unmasked && !i_op_start_qualifier) begin
      err = 1'b1;
    end else if (i_pwrite && is_opw && halted_q) begin
      err = 1'b1;
    end else if (!i_pwrite && is_opw) begin
      err = 1'b1;
    end
  end
  assign o_pslverr = access && err;
  assign wr_ok = done && i_pwrite && !err;

  always_comb begin
    rdata = 32'h0000_0000;
    case (i_paddr)
      fpc_pkg::A_MODE: begin
        rdata = mode_q;
      end
      fpc_pkg::A_STATUS: begin
        rdata[fpc_pkg::EXC_W-1:0] = exc_q;
        rdata[fpc_pkg::STAT_ES_BIT] = es_q;
      end
      fpc_pkg::A_MASK: begin
        rdata[fpc_pkg::EXC_W-1:0] = mask_q;
      end
      fpc_pkg::A_PREC: begin
        rdata = prec_q;
      end
      fpc_pkg::A_RES_HI: begin
        rdata = f_q[63:32];
      end
      fpc_pkg::A_RES_LO: begin
        rdata = f_q[31:0];
      end
      fpc_pkg::A_FLAGS: begin
        rdata[fpc_pkg::FLG_W-1:0] = flg_q;
      end
      fpc_pkg::A_SAVE_R: begin
        rdata = r_q;
      end
      fpc_pkg::A_SAVE_S: begin
        rdata = s_q;
      end
      fpc_pkg::A_SAVE_I: begin
        rdata = i_q;
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
  end
  assign o_prdata = (access && !i_pwrite && !err) ? rdata : 32'h0000_0000;

  // Operands of the starting operation; unwritten holding registers fall back to working ones
  assign new_r = r_w_q ? r_tmp_q : r_q;
  assign new_s = s_w_q ? s_tmp_q : s_q;
  assign new_i = i_w_q ? i_tmp_q : i_q;
  assign opc = new_i[fpc_pkg::OPC_LSB +: fpc_pkg::OPC_W];
  // Register file is read at start, before any result of this operation exists
  assign opnd_s = new_i[fpc_pkg::SRCRF_BIT] ? rf_q[new_i[fpc_pkg::SRC_LSB +: fpc_pkg::SEL_W]] : new_s;

  always_comb begin
    nst = STAGE_NONE;
    nst.vld = 1'b1;
    nst.mac = (opc == fpc_pkg::OPC_MAC);
    case (opc)
      fpc_pkg::OPC_ADD: begin
        nst.res = {32'h0000_0000, new_r} + {32'h0000_0000, opnd_s};
      end
      fpc_pkg::OPC_SUB: begin
        nst.res = {32'h0000_0000, new_r} - {32'h0000_0000, opnd_s};
      end
      fpc_pkg::OPC_MAC: begin
        nst.res = ({32'h0000_0000, new_r} * {32'h0000_0000, opnd_s}) +
                  {32'h0000_0000, rf_q[new_i[fpc_pkg::DST_LSB +: fpc_pkg::SEL_W]]};
      end
      default: begin
        nst.res = 64'h0000_0000_0000_0000;
      end
    endcase
    nst.exc[fpc_pkg::EXC_OVF] = |nst.res[63:32];
    nst.exc[fpc_pkg::EXC_BADOP] = (opc == fpc_pkg::OPC_BAD);
    nst.flg[fpc_pkg::FLG_ZERO] = (nst.res[31:0] == 32'h0000_0000);
    nst.flg[fpc_pkg::FLG_NEG] = nst.res[31];
    nst.rfen = new_i[fpc_pkg::RFEN_BIT];
    nst.dst = new_i[fpc_pkg::DST_LSB +: fpc_pkg::SEL_W];
  end

  // Stage timing; values below the legal floor are run as the floor
  always_comb begin
    if (pl) begin
      len_raw = mode_q[fpc_pkg::STAGE_LSB +: fpc_pkg::CNT_W];
    end else if (nst.mac) begin
      len_raw = mode_q[fpc_pkg::MACFT_LSB +: fpc_pkg::CNT_W];
    end else begin
      len_raw = mode_q[fpc_pkg::MOVEFT_LSB +: fpc_pkg::CNT_W];
    end
    len = (len_raw < fpc_pkg::STAGE_MIN) ? fpc_pkg::STAGE_MIN : len_raw;
  end
  assign timer_ok = cyc_q >= 4'(len - fpc_pkg::CNT_ONE);
  assign start = pending_q && timer_ok && !halted_q;
  // Flow-through hands the new result straight out; pipeline pushes the last stage out
  assign out = pl ? s3_q : nst;
  assign out_fault = out.vld && |(out.exc & ~mask_q);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cyc_q <= fpc_pkg::CNT_MAX;
    end else if (start) begin
      cyc_q <= 4'h0;
    end else if (cyc_q != fpc_pkg::CNT_MAX) begin
      cyc_q <= cyc_q + 4'h1;
    end
  end

  // Holding registers; only the start qualifier marks an operation fully specified
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_tmp_q <= 32'h0000_0000;
      s_tmp_q <= 32'h0000_0000;
      i_tmp_q <= 32'h0000_0000;
      r_w_q <= 1'b0;
      s_w_q <= 1'b0;
      i_w_q <= 1'b0;
      pending_q <= 1'b0;
    end else if (start) begin
      r_w_q <= 1'b0;
      s_w_q <= 1'b0;
      i_w_q <= 1'b0;
      pending_q <= 1'b0;
    end else if (wr_ok && is_opw) begin
      if (i_paddr == fpc_pkg::A_OPR_R) begin
        r_tmp_q <= i_pwdata;
        r_w_q <= 1'b1;
      end else if (i_paddr == fpc_pkg::A_OPR_S) begin
        s_tmp_q <= i_pwdata;
        s_w_q <= 1'b1;
      end else begin
        i_tmp_q <= i_pwdata;
        i_w_q <= 1'b1;
      end
      if (i_op_start_qualifier) begin
        pending_q <= 1'b1;
      end
    end
  end

  // Working registers change only at a start
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r_q <= 32'h0000_0000;
      s_q <= 32'h0000_0000;
      i_q <= 32'h0000_0000;
    end else if (start) begin
      r_q <= new_r;
      s_q <= new_s;
      i_q <= new_i;
    end
  end

  // Invalidation outranks a start in the same cycle: the host is expected to read first
  assign inval = pl && wr_ok && (i_paddr == fpc_pkg::A_STATUS) && i_op_start_qualifier;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= STAGE_NONE;
      s2_q <= STAGE_NONE;
      s3_q <= STAGE_NONE;
    end else if (inval || (wr_ok && (i_paddr == fpc_pkg::A_MODE) &&
                           !pl && i_pwdata[fpc_pkg::MODE_PL_BIT])) begin
      s1_q.vld <= 1'b0;
      s2_q.vld <= 1'b0;
      s3_q.vld <= 1'b0;
    end else if (start && pl) begin
      s1_q <= nst;
      // Non-MAC work skips the middle stage only while it is empty; a MAC after it leaves a bubble behind
      s2_q <= (s1_q.mac || s2_q.vld) ? s1_q : STAGE_NONE;
      s3_q <= s2_q.vld ? s2_q : ((s1_q.vld && !s1_q.mac) ? s1_q : STAGE_NONE);
    end
  end

  // Output registers load even for invalid results; only status, halt and file are guarded
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      f_q <= 64'h0000_0000_0000_0000;
      flg_q <= '0;
    end else if (start) begin
      f_q <= out.res;
      flg_q <= out.flg;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 0; k < fpc_pkg::RF_DEPTH; k++) begin
        rf_q[k] <= 32'h0000_0000;
      end
    end else if (start && out.vld && out.rfen) begin
      rf_q[out.dst] <= out.res[31:0];
    end
  end

  // Status: a hardware set wins over a host write in the same cycle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      exc_q <= '0;
      es_q <= 1'b0;
    end else begin
      if (wr_ok && (i_paddr == fpc_pkg::A_STATUS)) begin
        exc_q <= i_pwdata[fpc_pkg::EXC_W-1:0] | ((start && out.vld) ? out.exc : '0);
        es_q <= i_pwdata[fpc_pkg::STAT_ES_BIT] | (start && out_fault);
      end else if (start && out.vld) begin
        exc_q <= exc_q | out.exc;
        es_q <= es_q | out_fault;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      halted_q <= 1'b0;
    end else if (start && hen && out_fault) begin
      halted_q <= 1'b1;
    end else if (halted_q && !es_q && !unmasked) begin
      halted_q <= 1'b0;
    end
  end
  assign o_coproc_available = !halted_q;

  // Precision is host-owned; results never write it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= fpc_pkg::MODE_RST;
      mask_q <= '0;
      prec_q <= 32'h0000_0000;
    end else if (wr_ok) begin
      if (i_paddr == fpc_pkg::A_MODE) begin
        mode_q <= i_pwdata;
      end
      if (i_paddr == fpc_pkg::A_MASK) begin
        mask_q <= i_pwdata[fpc_pkg::EXC_W-1:0];
      end
      if (i_paddr == fpc_pkg::A_PREC) begin
        prec_q <= i_pwdata;
      end
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  a_start_gap: assert property (start |=> !start)
    else $error("two starts closer than the stage time");
  a_read_stall: assert property (access && !i_pwrite && is_out_rd && pending_q && !halted_q
                                 |-> !o_pready)
    else $error("output read not held off behind pending operation");
  a_save_refuse: assert property (access && is_save && pl |-> o_pslverr && o_pready)
    else $error("save state answered in pipeline mode");
  a_read_fault: assert property (access && o_pready && !i_pwrite && is_out_rd && mapped
                                 |-> o_pslverr == (unmasked && !i_op_start_qualifier))
    else $error("read-time fault wrong");
  a_halt_drop: assert property (start && hen && out_fault && !halted_q
                                |=> !o_coproc_available)
    else $error("coprocessor-available not dropped on faulting result");
  a_halt_write: assert property (access && i_pwrite && is_opw && halted_q
                                 |-> o_pslverr ##1 (r_tmp_q == $past(r_tmp_q) &&
                                 s_tmp_q == $past(s_tmp_q) && i_tmp_q == $past(i_tmp_q)))
    else $error("write accepted while halted");
  a_halt_hold: assert property (halted_q |-> !start ##1 (r_q == $past(r_q) && i_q == $past(i_q)))
    else $error("working registers moved during halt");
  a_resume_start: assert property (halted_q && !es_q && !unmasked
                                   |=> !halted_q && (start == (pending_q && timer_ok)))
    else $error("halt not lifted or pending operation not started after clear");
  a_invalid_status: assert property (start && pl && !s3_q.vld && !(wr_ok && i_paddr == fpc_pkg::A_STATUS)
                                     |=> $stable(exc_q) && $stable(es_q))
    else $error("invalid result changed status");
  a_mode_inval: assert property (wr_ok && i_paddr == fpc_pkg::A_MODE && !pl && i_pwdata[fpc_pkg::MODE_PL_BIT]
                                 |=> !s1_q.vld && !s2_q.vld && !s3_q.vld)
    else $error("switch into pipeline mode left valid stages");
  a_manual_inval: assert property (inval |=> !s1_q.vld && !s2_q.vld && !s3_q.vld)
    else $error("manual invalidation left valid stages");

  c_pipe_start: cover property (start && pl && s3_q.vld);
  c_read_stall: cover property (stall && !i_pwrite ##[1:20] done);
  c_halt: cover property ($rose(halted_q) ##[1:50] $fell(halted_q));
  c_mac_bubble: cover property (start && pl && nst.mac && s1_q.vld && !s1_q.mac);
endmodule
`default_nettype wire

// ### hdl/fpc_pkg.sv
// Constants and types for the floating-point accelerator pipeline-mode control block
// Contract
// - Accept next operation into holding registers while previous sits in stage one
// - At start copy only holding registers written for that operation
// - Once next operation is specified, stall output reads until it starts; the code does not stall them while halted
// - Save-state request is refused while pipeline mode is selected
// - In flow-through mode save-state returns operand and instruction registers only
// - Unmasked exception makes result, flag and status reads return fault
// - Read issued with start qualifier suppresses the read-time fault
// - Halt on fault only while the halt enable mode bit is high
// - Halt drops coprocessor-available when faulting result leaves last stage
// - While halted, operand and instruction writes fault and change nothing
// - Halt keeps working registers and any pending operation untouched
// - Clearing summary and causing exception bits resumes and starts pending work
// - Invalid result updates neither status, register file nor precision
// - Flow-through to pipeline mode switch invalidates all pipeline contents
// - Multiply-accumulate after other operation inserts one invalid spurious result; here only while the middle stage is empty
// - Status write with qualifier invalidates pipeline; never in flow-through mode
// - Stages take settings from the live mode register
// - Register-file write bit stores result at destination select location
// - Result written to register file is not usable by next operation; in flow-through mode the code lets the next operation read it
// - Pipeline mode timing uses only the stage cycle count field
// - Three stages for multiply-accumulate, two for all other operations; others take three here once the middle stage holds a valid entry
// - Pipeline advances only when a new operation starts
// - Stage cycle count gives cycles per stage, legal from 2 to 15
package fpc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_PREC = 8'h0C;
  localparam logic [7:0] A_OPR_R = 8'h10;
  localparam logic [7:0] A_OPR_S = 8'h14;
  localparam logic [7:0] A_INSTR = 8'h18;
  localparam logic [7:0] A_RES_HI = 8'h1C;
  localparam logic [7:0] A_RES_LO = 8'h20;
  localparam logic [7:0] A_FLAGS = 8'h24;
  localparam logic [7:0] A_SAVE_R = 8'h28;
  localparam logic [7:0] A_SAVE_S = 8'h2C;
  localparam logic [7:0] A_SAVE_I = 8'h30;
  // Mode register fields
  localparam int unsigned MODE_PL_BIT = 0;
  localparam int unsigned MODE_HALT_BIT = 1;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned STAGE_LSB = 4;
  localparam int unsigned MACFT_LSB = 8;
  localparam int unsigned MOVEFT_LSB = 12;
  localparam logic [3:0] STAGE_MIN = 4'h2;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  // Instruction fields
  localparam int unsigned OPC_LSB = 0;
  localparam int unsigned OPC_W = 2;
  localparam int unsigned RFEN_BIT = 4;
  localparam int unsigned DST_LSB = 5;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned SRCRF_BIT = 8;
  localparam int unsigned SRC_LSB = 9;
  localparam logic [1:0] OPC_ADD = 2'h0;
  localparam logic [1:0] OPC_MAC = 2'h1;
  localparam logic [1:0] OPC_SUB = 2'h2;
  localparam logic [1:0] OPC_BAD = 2'h3;
  // Status and flags
  localparam int unsigned EXC_W = 2;
  localparam int unsigned EXC_OVF = 0;
  localparam int unsigned EXC_BADOP = 1;
  localparam int unsigned STAT_ES_BIT = 7;
  localparam int unsigned FLG_W = 2;
  localparam int unsigned FLG_ZERO = 0;
  localparam int unsigned FLG_NEG = 1;
  localparam int unsigned RF_DEPTH = 8;
  typedef struct packed {
    logic vld;
    logic mac;
    logic [63:0] res;
    logic [EXC_W-1:0] exc;
    logic [FLG_W-1:0] flg;
    logic rfen;
    logic [SEL_W-1:0] dst;
  } fpc_stage_t;
endpackage

// ### tb/fpc_host_model.sv
// Host-side APB master model issuing the accelerator's transaction requests
`timescale 1ns/1ps
`default_nettype none
module fpc_host_model (
  // Clock
  input wire logic i_sys_clk,
  // Bus answer
  input wire logic [31:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_pslverr,
  // Bus request
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  output logic o_op_start_qualifier
);
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
    o_op_start_qualifier = 1'b0;
  end

  // One transfer; waits as long as the slave stalls, only the bench timeout ends a hang
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata, input logic qual,
                      output logic [31:0] rdata, output logic err);
    @(posedge i_sys_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= wr;
    o_paddr <= addr;
    o_pwdata <= wdata;
    o_op_start_qualifier <= qual;
    @(posedge i_sys_clk);
    o_penable <= 1'b1;
    do @(posedge i_sys_clk); while (i_pready !== 1'b1);
    rdata = i_prdata;
    err = i_pslverr;
    // Released address and data lines show the inverse so a stale value is never mistaken for a live one
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    o_paddr <= ~addr;
    o_pwdata <= ~wdata;
    o_op_start_qualifier <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/fpc_pipe_ctrl_bench.sv
// Self-checking bench for the pipeline-mode control block
`timescale 1ns/1ps
`default_nettype none
module fpc_pipe_ctrl_bench;
  logic clk;
  logic rst;
  logic psel, penable, pwrite, qual, pready, pslverr, avail, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  fpc_pipe_ctrl i_dut (.i_sys_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_op_start_qualifier(qual), .o_coproc_available(avail));

  fpc_host_model i_host (.i_sys_clk(clk), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr),
    .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .o_op_start_qualifier(qual));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Transfer, then compare error answer and, for a clean read, the data
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d, input logic q, input logic e);
    i_host.xfer(w, a, d, q, rd, er);
    chk({31'h0000_0000, er}, {31'h0000_0000, e});
    if (!w && !e) begin
      chk(rd, d);
    end
  endtask

  // Bounded wait for the availability output to reach a level
  task automatic wait_avail(input logic lvl);
    n = 0;
    while (avail !== lvl && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0000_0000, avail}, {31'h0000_0000, lvl});
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rw(1'b0, fpc_pkg::A_MODE, 32'h0000_0000, 1'b0, 1'b0);
    chk({31'h0000_0000, avail}, 32'h0000_0001);
    rw(1'b0, 8'h40, 32'h0000_0000, 1'b0, 1'b1);
    rw(1'b1, fpc_pkg::A_SAVE_R, 32'h0000_0005, 1'b0, 1'b1);
    $display("test reset and map done");
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0005, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0007, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_INSTR, 32'h0000_0070, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_000C, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_HI, 32'h0000_0000, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_FLAGS, 32'h0000_0000, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0001, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_0006, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_SAVE_R, 32'h0000_0005, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_SAVE_S, 32'h0000_0001, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_SAVE_I, 32'h0000_0070, 1'b0, 1'b0);
    $display("test flow-through operation done");
    rw(1'b1, fpc_pkg::A_OPR_R, 32'hFFFF_FFFF, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0001, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_0000, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_HI, 32'h0000_0000, 1'b0, 1'b1);
    rw(1'b0, fpc_pkg::A_FLAGS, 32'h0000_0000, 1'b0, 1'b1);
    rw(1'b0, fpc_pkg::A_STATUS, 32'h0000_0000, 1'b0, 1'b1);
    chk({31'h0000_0000, avail}, 32'h0000_0001);
    rw(1'b1, fpc_pkg::A_MASK, 32'h0000_0001, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_HI, 32'h0000_0001, 1'b0, 1'b0);
    $display("test read fault done");
    rw(1'b0, fpc_pkg::A_MODE, 32'h0000_0000, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_MODE, 32'h0000_0002, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_STATUS, 32'h0000_0000, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_MASK, 32'h0000_0000, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0001, 1'b1, 1'b0);
    wait_avail(1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0009, 1'b0, 1'b1);
    rw(1'b1, fpc_pkg::A_INSTR, 32'h0000_0000, 1'b0, 1'b1);
    rw(1'b0, fpc_pkg::A_SAVE_R, 32'hFFFF_FFFF, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_SAVE_I, 32'h0000_0070, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_STATUS, 32'h0000_0000, 1'b0, 1'b0);
    wait_avail(1'b1);
    $display("test halt done");
    rw(1'b0, fpc_pkg::A_MODE, 32'h0000_0002, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_MODE, 32'h0000_0021, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_SAVE_R, 32'h0000_0000, 1'b0, 1'b1);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0001, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_STATUS, 32'h0000_0000, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0003, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0004, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_000A, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0001, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0002, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0002, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_0007, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_STATUS, 32'h0000_0000, 1'b1, 1'b0);
    $display("test pipeline done");
    // Subtract taking S from file slot 3, which the same start overwrites with an older result
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0010, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_INSTR, 32'h0000_0702, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_000B, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0001, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_INSTR, 32'h0000_0700, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0000, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_0009, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0000, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_000C, 1'b0, 1'b0);
    $display("test register file done");
    // Multiply-accumulate after adds: one spurious zero result, then the product three starts later
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0003, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0005, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_INSTR, 32'h0000_0001, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_INSTR, 32'h0000_0000, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0002, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_0000, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_R, 32'h0000_0001, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_000F, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_STATUS, 32'h0000_0000, 1'b0, 1'b0);
    $display("test mac bubble done");
    // Long flow-through stage time so the read meets a pending operation and must wait
    rw(1'b0, fpc_pkg::A_MODE, 32'h0000_0021, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_MODE, 32'h0000_F000, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0001, 1'b1, 1'b0);
    rw(1'b1, fpc_pkg::A_OPR_S, 32'h0000_0002, 1'b1, 1'b0);
    rw(1'b0, fpc_pkg::A_RES_LO, 32'h0000_0003, 1'b0, 1'b0);
    rw(1'b0, fpc_pkg::A_MODE, 32'h0000_F000, 1'b0, 1'b0);
    rw(1'b1, fpc_pkg::A_MODE, 32'h0000_0021, 1'b0, 1'b0);
    $display("test delayed read done");
    test_done();
  end
endmodule
`default_nettype wire
